// ===== pwr_seq_pkg.sv
// Purpose: Shared types and constants for the power state sequencer.
// Assumes: One 200 MHz clock; all timing is counted in cycles of it.
// Notes:   Step times are plain defaults, overridable; the slot count must stay five.
package pwr_seq_pkg;

  // ==========================================================================
  // Sizes and timing
  // ==========================================================================
  localparam int unsigned NUM_SLOTS     = 5;
  localparam int unsigned NUM_OUTS      = 16;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SLOT_TIME_NS  = 1000;
  localparam int unsigned SLOT_CYCLES   = (SLOT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [15:0] SLOT_CNT_RST  = 16'h0000;

  // Bit positions within the enable vector.
  localparam int unsigned BIT_AO_LDO    = 0;
  localparam int unsigned BIT_SEQ_OUT1  = 14;
  localparam int unsigned BIT_SEQ_OUT2  = 15;

  // ==========================================================================
  // Power states, one-hot
  // ==========================================================================
  typedef enum logic [5:0] {
    ST_NO_POWER = 6'h01,
    ST_OFF      = 6'h02,
    ST_ON       = 6'h04,
    ST_SLEEP    = 6'h08,
    ST_BACKUP   = 6'h10,
    ST_PROGRAM  = 6'h20
  } pstate_t;

  // One slot of a sequence: which outputs switch in this slot.
  typedef struct packed {
    logic [NUM_OUTS-1:0] on_mask;
    logic [NUM_OUTS-1:0] off_mask;
  } slot_t;

  // Transition requests from the host and autonomous sources.
  typedef struct packed {
    logic on_req;
    logic off_req;
    logic sleep_req;
    logic wake_req;
  } req_t;

  // Whole state of the sequencer.
  typedef struct packed {
    pstate_t             st;
    pstate_t             target;
    logic                busy;
    logic [2:0]          slot;
    logic [15:0]         cnt;
    logic [NUM_OUTS-1:0] en;
    logic                rst_out_n;
    logic                rtc_run;
    logic                cfg_ext;
    logic                otp_wr;
    logic [2:0]          por_s;
    logic [2:0]          dr_s;
  } seq_state_t;

endpackage : pwr_seq_pkg

// ===== power_state_sequencer.sv
// Purpose: Power state controller with slotted converter sequences.
// Assumes: Supply monitors are asynchronous levels; requests are same-clock.
// Notes:   Tables reload only in no-power; requests during a sequence are dropped.
// Contract
// - Five timed slots order enables and disables
// - Config from internal memory, plus external
// - External configuration overrides internal values
// - Host rewrites sequence in off state
// - Six power states implemented
// - No-power: all inactive, registers lost
// - Off: clock runs, retain, reset low
// - Off: all disabled except kept regulators
// - On: all functions available
// - Sleep entry and exit run sequences
// - Backup disables every converter output
// - Backup keeps clock, oscillator, scratch only
// - Unclocked backup freezes real-time clock
// - Below power-on threshold means no-power
// - Below device-reset threshold enters backup
// - Off/on/sleep transitions are timed sequences
// - Commands, watchdog, pin, autonomous triggers
// - Program state writes one-time memory
// - Self-program memory from external EEPROM
// - Control outputs switch within sequences
`timescale 1ns/1ps

module power_state_sequencer #(
  parameter int unsigned SLOTS = pwr_seq_pkg::NUM_SLOTS,
  parameter int unsigned SLOT_LEN = pwr_seq_pkg::SLOT_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              por_ok,
  input  wire logic                              dev_ok,
  input  wire logic                              on_pin_n,
  input  wire pwr_seq_pkg::req_t                 host_req,
  input  wire pwr_seq_pkg::req_t                 auto_req,
  input  wire logic                              wdog_off,
  input  wire logic                              prog_enter,
  input  wire logic                              prog_exit,
  input  wire logic                              prog_from_eeprom,
  input  wire logic                              ao_ldo_keep,
  input  wire logic                              unclocked_backup,
  input  wire logic                              eeprom_present,
  input  wire pwr_seq_pkg::slot_t [4:0]          otp_up,
  input  wire pwr_seq_pkg::slot_t [4:0]          otp_sleep,
  input  wire pwr_seq_pkg::slot_t [4:0]          eep_up,
  input  wire pwr_seq_pkg::slot_t [4:0]          eep_sleep,
  input  wire logic                              host_seq_wr,
  input  wire logic [2:0]                        host_seq_idx,
  input  wire logic                              host_seq_sel,
  input  wire pwr_seq_pkg::slot_t                host_seq_data,
  output logic [pwr_seq_pkg::NUM_OUTS-1:0]       rail_en,
  output logic                                   seq_out1,
  output logic                                   seq_out2,
  output logic                                   sys_rst_n,
  output logic                                   rtc_run,
  output logic                                   regs_clear,
  output logic                                   otp_write,
  output logic                                   cfg_from_eeprom,
  output pwr_seq_pkg::pstate_t                   pstate,
  output logic                                   seq_busy
);

  // The table ports are five entries wide and the slot counter is 16 bits.
  if (SLOTS != 5 || SLOT_LEN < 1 || SLOT_LEN > 65535) begin : g_bad_params
    $error("power_state_sequencer: unsupported parameters");
  end

  // ==========================================================================
  // Sequence tables
  // ==========================================================================
  // Up table is walked forward on power-up and backward on power-down. The
  // sleep table is applied on entry and inverted on exit.
  pwr_seq_pkg::slot_t [4:0] up_q, sleep_q;
  pwr_seq_pkg::seq_state_t  s_q, s_d;
  logic                     pin_s1_q, pin_s2_q, pin_s3_q;

  // Load from internal memory, with external data winning when present, and
  // accept host rewrites only while off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q    <= '0;
      sleep_q <= '0;
    end else if (!s_q.por_s[2]) begin
      up_q    <= eeprom_present ? eep_up : otp_up;
      sleep_q <= eeprom_present ? eep_sleep : otp_sleep;
    end else if (host_seq_wr && s_q.st == pwr_seq_pkg::ST_OFF &&
                 host_seq_idx < 3'h5) begin
      if (host_seq_sel) sleep_q[host_seq_idx] <= host_seq_data;
      else up_q[host_seq_idx] <= host_seq_data;
    end
  end

  // On pin is asynchronous: two stages, then an edge from the third.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= on_pin_n;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  function automatic pwr_seq_pkg::slot_t pick(input pwr_seq_pkg::slot_t [4:0] t,
                                              input logic [2:0] i);
    pick = t[i];
  endfunction : pick

  // ==========================================================================
  // State machine
  // ==========================================================================
  logic pin_press;
  logic want_on, want_off, want_sleep, want_wake;
  pwr_seq_pkg::slot_t cur;
  pwr_seq_pkg::slot_t up_fwd, up_rev, sl_fwd, sl_rev;

  // Forward and reversed entries of both tables for the current slot.
  assign up_fwd = pick(up_q, s_q.slot);
  assign up_rev = pick(up_q, 3'h4 - s_q.slot);
  assign sl_fwd = pick(sleep_q, s_q.slot);
  assign sl_rev = pick(sleep_q, 3'h4 - s_q.slot);

  assign pin_press  = pin_s3_q && !pin_s2_q;
  assign want_on    = host_req.on_req || auto_req.on_req || pin_press;
  assign want_off   = host_req.off_req || auto_req.off_req || wdog_off;
  assign want_sleep = host_req.sleep_req || auto_req.sleep_req;
  assign want_wake  = host_req.wake_req || auto_req.wake_req || pin_press;

  // Pick the slot entry for the running sequence; walking down reverses order,
  // so the last rail to come up is the first one to go down.
  always_comb begin
    cur = '0;
    if (s_q.target == pwr_seq_pkg::ST_ON && s_q.st == pwr_seq_pkg::ST_OFF)
      cur = up_fwd;
    else if (s_q.target == pwr_seq_pkg::ST_OFF) begin
      cur.off_mask = up_rev.on_mask;
      cur.on_mask  = '0;
    end else if (s_q.target == pwr_seq_pkg::ST_SLEEP)
      cur = sl_fwd;
    else if (s_q.target == pwr_seq_pkg::ST_ON) begin
      cur.on_mask  = sl_rev.off_mask;
      cur.off_mask = sl_rev.on_mask;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.por_s = {s_q.por_s[1:0], por_ok};
    s_d.dr_s  = {s_q.dr_s[1:0], dev_ok};
    s_d.otp_wr = 1'b0;
    if (!s_q.por_s[2]) begin
      // Supply below power-on threshold: everything is gone.
      s_d.st = pwr_seq_pkg::ST_NO_POWER;
      s_d.busy = 1'b0;
      s_d.en = '0;
      s_d.rst_out_n = 1'b0;
      s_d.rtc_run = 1'b0;
      s_d.cfg_ext = eeprom_present;
    end else if (!s_q.dr_s[2]) begin
      // Brown-out preempts any sequence in progress.
      s_d.st = pwr_seq_pkg::ST_BACKUP;
      s_d.busy = 1'b0;
      s_d.en = '0;
      s_d.rst_out_n = 1'b0;
      s_d.rtc_run = !unclocked_backup;
    end else if (s_q.busy) begin
      // Apply this slot's masks once per slot period.
      if (s_q.cnt == 16'(SLOT_LEN - 1)) begin
        s_d.en  = (s_q.en & ~cur.off_mask) | cur.on_mask;
        s_d.cnt = pwr_seq_pkg::SLOT_CNT_RST;
        if (s_q.slot == 3'(SLOTS - 1)) begin
          s_d.busy = 1'b0;
          s_d.st = s_q.target;
          s_d.rst_out_n = (s_q.target != pwr_seq_pkg::ST_OFF);
          if (s_q.target == pwr_seq_pkg::ST_OFF)
            s_d.en = ao_ldo_keep ? pwr_seq_pkg::NUM_OUTS'(1) : '0;
        end else begin
          s_d.slot = s_q.slot + 3'h1;
        end
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end else begin
      // Idle: one request at a time is accepted.
      s_d.rtc_run = 1'b1;
      s_d.slot = 3'h0;
      s_d.cnt = pwr_seq_pkg::SLOT_CNT_RST;
      case (s_q.st)
        pwr_seq_pkg::ST_NO_POWER, pwr_seq_pkg::ST_BACKUP: begin
          s_d.st = pwr_seq_pkg::ST_OFF;
          s_d.rst_out_n = 1'b0;
          s_d.en = ao_ldo_keep ? pwr_seq_pkg::NUM_OUTS'(1) : '0;
        end
        pwr_seq_pkg::ST_OFF: begin
          if (prog_enter) begin
            s_d.st = pwr_seq_pkg::ST_PROGRAM;
            s_d.cfg_ext = prog_from_eeprom;
          end else if (want_on) begin
            s_d.busy = 1'b1;
            s_d.target = pwr_seq_pkg::ST_ON;
          end
        end
        pwr_seq_pkg::ST_ON: begin
          if (want_off) begin
            s_d.busy = 1'b1;
            s_d.target = pwr_seq_pkg::ST_OFF;
            s_d.rst_out_n = 1'b0;
          end else if (want_sleep) begin
            s_d.busy = 1'b1;
            s_d.target = pwr_seq_pkg::ST_SLEEP;
          end
        end
        pwr_seq_pkg::ST_SLEEP: begin
          if (want_off) begin
            s_d.busy = 1'b1;
            s_d.target = pwr_seq_pkg::ST_OFF;
            s_d.rst_out_n = 1'b0;
          end else if (want_wake) begin
            s_d.busy = 1'b1;
            s_d.target = pwr_seq_pkg::ST_ON;
          end
        end
        pwr_seq_pkg::ST_PROGRAM: begin
          s_d.otp_wr = 1'b1;
          if (prog_exit) s_d.st = pwr_seq_pkg::ST_OFF;
        end
        default: s_d.st = pwr_seq_pkg::ST_NO_POWER;
      endcase
    end
  end

  // The whole state is one register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= pwr_seq_pkg::ST_NO_POWER;
      s_q.target <= pwr_seq_pkg::ST_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rail_en         = s_q.en;
  assign seq_out1        = s_q.en[pwr_seq_pkg::BIT_SEQ_OUT1];
  assign seq_out2        = s_q.en[pwr_seq_pkg::BIT_SEQ_OUT2];
  assign sys_rst_n       = s_q.rst_out_n;
  assign rtc_run         = s_q.rtc_run;
  assign regs_clear      = (s_q.st == pwr_seq_pkg::ST_NO_POWER) ||
                           (s_q.st == pwr_seq_pkg::ST_BACKUP);
  assign otp_write       = s_q.otp_wr;
  assign cfg_from_eeprom = s_q.cfg_ext;
  assign pstate          = s_q.st;
  assign seq_busy        = s_q.busy;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_backup_rails_off: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.st == pwr_seq_pkg::ST_BACKUP |-> rail_en == '0)
    else $error("rails on in backup");
  a_off_reset_low: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.st == pwr_seq_pkg::ST_OFF |-> !sys_rst_n && rtc_run)
    else $error("off state reset or clock wrong");
  a_off_rails_kept: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.st == pwr_seq_pkg::ST_OFF && !s_q.busy |-> (rail_en & 16'hFFFE) == 16'h0000)
    else $error("rails on in off");
  a_nopower_entry: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.por_s[2] |=> pstate == pwr_seq_pkg::ST_NO_POWER && rail_en == '0)
    else $error("no-power not entered");
  a_backup_entry: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.por_s[2] && !s_q.dr_s[2] |=> pstate == pwr_seq_pkg::ST_BACKUP)
    else $error("backup not entered");
  a_unclocked_rtc: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.st == pwr_seq_pkg::ST_BACKUP && $past(unclocked_backup) |-> !rtc_run)
    else $error("rtc runs in unclocked backup");
  a_busy_holds_st: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.busy && s_d.busy && s_q.dr_s[2] |=> $stable(pstate))
    else $error("state changed during sequence");
  a_state_onehot: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot(pstate))
    else $error("power state not one-hot");
  a_program_write: assert property (@(posedge clk) disable iff (!rst_n)
    otp_write |-> $past(pstate) == pwr_seq_pkg::ST_PROGRAM)
    else $error("memory write outside program");

  // Sequencing and table guards. A rail may only move at a slot boundary, so a
  // converter never sees two enables closer together than one slot period.
  a_slot_rails_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.busy && s_q.cnt != 16'(SLOT_LEN - 1) && s_q.por_s[2] && s_q.dr_s[2]
    |=> $stable(rail_en))
    else $error("rails moved inside a slot");
  a_table_write_gate: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.por_s[2] && !(host_seq_wr && s_q.st == pwr_seq_pkg::ST_OFF)
    |=> $stable(up_q) && $stable(sleep_q))
    else $error("sequence table changed outside off");
  a_eeprom_override: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.por_s[2] && eeprom_present
    |=> up_q == $past(eep_up) && sleep_q == $past(eep_sleep))
    else $error("external tables not loaded");
  a_nopower_cfg: assert property (@(posedge clk) disable iff (!rst_n)
    !s_q.por_s[2]
    |=> cfg_from_eeprom == $past(eeprom_present))
    else $error("config source not captured");
  a_on_reset_high: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.st == pwr_seq_pkg::ST_ON && !s_q.busy
    |-> sys_rst_n)
    else $error("system held in reset while on");

endmodule : power_state_sequencer

// ===== host_eeprom_model.sv
// Purpose: Host and configuration memory model facing the sequencer.
// Assumes: Host requests are levels held until the sequencer goes busy.
// Notes:   Memory tables differ from the internal ones to expose the override.
`timescale 1ns/1ps

module host_eeprom_model (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    seq_busy,
  input  wire logic                    go,
  input  wire pwr_seq_pkg::req_t       cmd,
  output pwr_seq_pkg::req_t            host_req,
  output pwr_seq_pkg::slot_t [4:0]     eep_up,
  output pwr_seq_pkg::slot_t [4:0]     eep_sleep
);
  // ==========================================================================
  // Request holding
  // ==========================================================================
  // The request drops once taken, since a level left up would be taken again.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) host_req <= '0;
    else if (go) host_req <= cmd;
    else if (seq_busy) host_req <= '0;
  end

  // ==========================================================================
  // Memory contents
  // ==========================================================================
  // Rails 4 to 6 then the two control outputs; sleep drops rail 4.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      eep_up[i].on_mask     = (i < 3) ? (16'h0010 << i) : (16'h4000 << (i - 3));
      eep_up[i].off_mask    = 16'h0000;
      eep_sleep[i].on_mask  = 16'h0000;
      eep_sleep[i].off_mask = (i == 0) ? 16'h0010 : 16'h0000;
    end
  end
endmodule : host_eeprom_model

// ===== testbench.sv
// Purpose: Self-checking bench for the power state sequencer.
// Assumes: Slots shortened to SL cycles; supply changes settle in 8 cycles.
// Notes:   Internal tables use rails 1 to 3, memory tables rails 4 to 6.
`timescale 1ns/1ps

module testbench;
  localparam int SL = 3;
  typedef struct packed {
    logic [1:0] src;
    logic [1:0] cmd;
    pwr_seq_pkg::pstate_t st;
    logic [15:0] rails;
    logic rst;
    logic [15:0] mid;
  } row_t;
  localparam row_t ROWS [6] = '{
    '{2'h0, 2'h0, pwr_seq_pkg::ST_ON,    16'hC00F, 1'b1, 16'h0002},
    '{2'h1, 2'h2, pwr_seq_pkg::ST_SLEEP, 16'hC00D, 1'b1, 16'hFFFF},
    '{2'h3, 2'h3, pwr_seq_pkg::ST_ON,    16'hC00F, 1'b1, 16'hFFFF},
    '{2'h2, 2'h1, pwr_seq_pkg::ST_OFF,   16'h0001, 1'b0, 16'hFFFF},
    '{2'h3, 2'h0, pwr_seq_pkg::ST_ON,    16'hC00F, 1'b1, 16'h0002},
    '{2'h0, 2'h1, pwr_seq_pkg::ST_OFF,   16'h0001, 1'b0, 16'hFFFF}};

  logic clk, rst_n, por_ok, dev_ok, on_pin_n, wdog_off, prog_enter, prog_exit;
  logic prog_from_eeprom, ao_ldo_keep, unclocked_backup, eeprom_present;
  logic host_seq_wr, host_seq_sel, host_go;
  logic [2:0] host_seq_idx;
  pwr_seq_pkg::req_t host_req, auto_req, host_cmd;
  pwr_seq_pkg::slot_t [4:0] otp_up, otp_sleep, eep_up, eep_sleep;
  pwr_seq_pkg::slot_t host_seq_data;
  logic [15:0] rail_en, mid_seen;
  logic seq_out1, seq_out2, sys_rst_n, rtc_run, regs_clear, otp_write, cfg_from_eeprom;
  logic seq_busy;
  pwr_seq_pkg::pstate_t pstate;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int busy_n;

  power_state_sequencer #(.SLOT_LEN(SL)) i_power_state_sequencer (.clk, .rst_n, .por_ok,
    .dev_ok, .on_pin_n, .host_req, .auto_req, .wdog_off, .prog_enter, .prog_exit,
    .prog_from_eeprom, .ao_ldo_keep, .unclocked_backup, .eeprom_present, .otp_up, .otp_sleep,
    .eep_up, .eep_sleep, .host_seq_wr, .host_seq_idx, .host_seq_sel, .host_seq_data, .rail_en,
    .seq_out1, .seq_out2, .sys_rst_n, .rtc_run, .regs_clear, .otp_write, .cfg_from_eeprom,
    .pstate, .seq_busy);
  host_eeprom_model i_host_eeprom_model (.clk, .rst_n, .seq_busy, .go(host_go),
    .cmd(host_cmd), .host_req, .eep_up, .eep_sleep);

  // ==========================================================================
  // Clock, internal tables and hang guard
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Internal tables: rails 1 to 3 then the control outputs; sleep drops rail 1.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      otp_up[i].on_mask     = (i < 3) ? (16'h0002 << i) : (16'h4000 << (i - 3));
      otp_up[i].off_mask    = 16'h0000;
      otp_sleep[i].on_mask  = 16'h0000;
      otp_sleep[i].off_mask = (i == 0) ? 16'h0002 : 16'h0000;
    end
  end
  // The whole run needs well under a thousand cycles, so this is generous.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      finish_test();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // Raises one request from one source and holds it until the sequencer is busy.
  task automatic start_req(input logic [1:0] src, input logic [1:0] cmd);
    pwr_seq_pkg::req_t r;
    r = pwr_seq_pkg::req_t'(4'h8 >> cmd);
    case (src)
      2'h0: begin
        host_cmd <= r;
        host_go  <= 1'b1;
      end
      2'h1: auto_req <= r;
      2'h2: wdog_off <= 1'b1;
      default: on_pin_n <= 1'b0;
    endcase
    @(posedge clk);
    host_go <= 1'b0;
    repeat (20) begin
      if (seq_busy === 1'b1) break;
      @(posedge clk);
    end
    auto_req <= '0;
    wdog_off <= 1'b0;
    on_pin_n <= 1'b1;
  endtask : start_req

  // Counts busy cycles and keeps the rails seen just after the first slot.
  task automatic wait_done();
    busy_n = 1;
    repeat (200) begin
      @(posedge clk);
      if (seq_busy !== 1'b1) break;
      busy_n++;
      if (busy_n == SL + 1) mid_seen = rail_en;
    end
  endtask : wait_done

  task automatic do_step(input row_t r);
    start_req(r.src, r.cmd);
    wait_done();
    chk("busy cycles", 16'(5 * SL), busy_n[15:0]);
    if (r.mid != 16'hFFFF) chk("first slot", r.mid, mid_seen & 16'hFFFE);
    chk("state", {10'h000, r.st}, {10'h000, pstate});
    chk("rails", r.rails, rail_en);
    chk("control outs", {14'h0000, r.rails[15:14]}, {14'h0000, seq_out2, seq_out1});
    chk("system reset", {15'h0000, r.rst}, {15'h0000, sys_rst_n});
    chk("rtc running", 16'h0001, {15'h0000, rtc_run});
    $display("step done, state %h", pstate);
  endtask : do_step

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {rst_n, on_pin_n, wdog_off, prog_enter, prog_exit, prog_from_eeprom} = 6'h10;
    {por_ok, dev_ok, ao_ldo_keep, unclocked_backup, eeprom_present} = 5'h1C;
    {host_seq_wr, host_seq_sel, host_go, host_seq_idx} = 6'h00;
    {host_cmd, auto_req, host_seq_data} = '0;
    repeat (4) @(posedge clk);
    chk("reset state", 16'h0001, {10'h000, pstate});
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("off state", 16'h0002, {10'h000, pstate});
    chk("off rails", 16'h0001, rail_en);
    chk("off reset", 16'h0000, {15'h0000, sys_rst_n});
    for (int i = 0; i < 6; i++) do_step(ROWS[i]);
    // A request raised mid-sequence is dropped, not queued.
    start_req(2'h0, 2'h0);
    repeat (3) @(posedge clk);
    auto_req <= 4'h4;
    @(posedge clk);
    auto_req <= '0;
    wait_done();
    chk("held off request", 16'h0004, {10'h000, pstate});
    repeat (2) @(posedge clk);
    chk("not queued", 16'h0000, {15'h0000, seq_busy});
    do_step(ROWS[5]);
    // Slot 4 rewritten in off; an index past the last slot must be refused.
    host_seq_wr   <= 1'b1;
    host_seq_idx  <= 3'h4;
    host_seq_data <= '{16'h2000, 16'h0000};
    @(posedge clk);
    host_seq_idx  <= 3'h5;
    host_seq_data <= '{16'h1000, 16'h0000};
    @(posedge clk);
    host_seq_wr <= 1'b0;
    do_step('{2'h0, 2'h0, pwr_seq_pkg::ST_ON, 16'h600F, 1'b1, 16'h0002});
    do_step(ROWS[5]);
    // Supply sag in mid-sequence preempts it, with and without the clock held.
    for (int u = 0; u < 2; u++) begin
      unclocked_backup <= u[0];
      start_req(2'h0, 2'h0);
      dev_ok <= 1'b0;
      repeat (8) @(posedge clk);
      chk("backup state", 16'h0010, {10'h000, pstate});
      chk("backup rails", 16'h0000, rail_en);
      chk("backup clear", 16'h0001, {15'h0000, regs_clear});
      chk("backup rtc", {15'h0000, ~u[0]}, {15'h0000, rtc_run});
      dev_ok <= 1'b1;
      repeat (8) @(posedge clk);
      chk("after backup", 16'h0002, {10'h000, pstate});
    end
    // Full power loss with the external memory attached reloads its tables.
    por_ok         <= 1'b0;
    eeprom_present <= 1'b1;
    repeat (8) @(posedge clk);
    chk("no power state", 16'h0001, {10'h000, pstate});
    chk("no power outs", 16'h0001, {rail_en[14:0], regs_clear});
    por_ok <= 1'b1;
    repeat (8) @(posedge clk);
    chk("config source", 16'h0001, {15'h0000, cfg_from_eeprom});
    do_step('{2'h1, 2'h0, pwr_seq_pkg::ST_ON, 16'hC071, 1'b1, 16'h0010});
    do_step('{2'h0, 2'h2, pwr_seq_pkg::ST_SLEEP, 16'hC061, 1'b1, 16'hFFFF});
    ao_ldo_keep <= 1'b0;
    do_step('{2'h0, 2'h1, pwr_seq_pkg::ST_OFF, 16'h0000, 1'b0, 16'hFFFF});
    // Program state entered and left through its own strobes.
    prog_from_eeprom <= 1'b1;
    prog_enter       <= 1'b1;
    @(posedge clk);
    prog_enter <= 1'b0;
    repeat (4) @(posedge clk);
    chk("program state", 16'h8003, {pstate, 8'h00, cfg_from_eeprom, otp_write});
    prog_exit <= 1'b1;
    @(posedge clk);
    prog_exit <= 1'b0;
    repeat (4) @(posedge clk);
    chk("program exit", 16'h0800, {pstate, 9'h000, otp_write});
    finish_test();
  end
endmodule : testbench
